//--- core/asp_pkg.sv
package asp_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [15:0] ADDR_PORT_ENABLE  = 16'h1518;
  localparam logic [15:0] ADDR_RX_PIN       = 16'h151d;
  localparam logic [15:0] ADDR_TX_PIN       = 16'h1522;
  localparam logic [15:0] ADDR_DATA_BITS    = 16'h1527;
  localparam logic [15:0] ADDR_SYMBOL_RATE  = 16'h152c;
  localparam logic [15:0] ADDR_RX_DEPTH     = 16'h1536;
  localparam logic [15:0] ADDR_RX_COUNT     = 16'h153b;
  localparam logic [15:0] ADDR_TX_COUNT     = 16'h1540;
  localparam logic [15:0] ADDR_TX_TRIGGER   = 16'h154a;
  localparam logic [15:0] ADDR_STOP_BITS    = 16'h154f;
  localparam logic [15:0] ADDR_PARITY       = 16'h1554;
  localparam logic [15:0] ADDR_PARITY_ERRS  = 16'h1559;
  localparam logic [15:0] ADDR_TX_DATA      = 16'h1572;
  localparam logic [15:0] ADDR_RX_DATA      = 16'h1577;

  // ==========================================================================
  // Reset values and field encodings
  localparam logic [15:0] CFG_RESET         = 16'h0000;
  localparam logic [31:0] RATE_RESET        = 32'h0000_2580;
  localparam logic [15:0] PIN_COUNT         = 16'h0010;
  localparam logic [15:0] PAR_NONE          = 16'h0000;
  localparam logic [15:0] PAR_ODD           = 16'h0001;
  localparam logic [15:0] PAR_EVEN          = 16'h0002;
  localparam logic [15:0] STOP_TWO          = 16'h0002;
  localparam logic [3:0]  DATA_BITS_MAX     = 4'h8;
  localparam logic [15:0] TRIGGER_GO        = 16'h0001;

  // ==========================================================================
  // Sizes and timing
  localparam logic [31:0] RATE_MAX          = 32'h0000_9600;
  localparam logic [11:0] RX_DEPTH_MAX      = 12'h800;
  localparam logic [11:0] RX_DEPTH_DEFAULT  = 12'h0c8;
  localparam logic [8:0]  TX_DEPTH          = 9'h100;
  localparam logic [27:0] CLK_HZ            = 28'h5f5_e100;
  localparam logic [3:0]  TICK_MID          = 4'h7;
  localparam logic [3:0]  TICK_LAST         = 4'hf;

  typedef enum logic [1:0] {
    ASP_RX_IDLE, ASP_RX_START, ASP_RX_DATA, ASP_RX_PARITY_STOP
  } asp_rx_state_t;

  typedef enum logic [2:0] {
    ASP_TX_IDLE, ASP_TX_LOAD, ASP_TX_START, ASP_TX_DATA, ASP_TX_PARITY,
    ASP_TX_STOP
  } asp_tx_state_t;

endpackage

//--- core/asp_tick_if.sv
`timescale 1ns/10ps
interface asp_tick_if;
  logic [15:0] rate;
  logic        run;
  logic        tick;

  modport gen  (input rate, input run, output tick);
  modport user (output rate, output run, input tick);
endinterface

//--- core/asp_rate_tick.sv
`timescale 1ns/10ps
// Sixteen ticks per symbol from a phase accumulator, so any rate works
// without a divider; the jitter is at most one clock per tick.
module asp_rate_tick (
  input  wire logic mclk,
  input  wire logic srst,
  asp_tick_if.gen   tk
);
  logic [27:0] acc_q;
  logic [27:0] acc_d;
  logic        tick_d;
  logic        tick_q;

  always_comb begin
    acc_d  = acc_q + {8'h00, tk.rate, 4'h0};
    tick_d = 1'b0;
    if (acc_d >= asp_pkg::CLK_HZ) begin
      acc_d  = acc_d - asp_pkg::CLK_HZ;
      tick_d = 1'b1;
    end
    if (!tk.run) begin
      acc_d  = 28'h0;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      acc_q  <= 28'h0;
      tick_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      tick_q <= tick_d;
    end
  end

  assign tk.tick = tick_q;
endmodule // asp_rate_tick

//--- core/asp_async_serial_port.sv
`timescale 1ns/10ps
module asp_async_serial_port (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [31:0] reg_rdata,
  input  wire logic [15:0] gp_in,
  output logic      [15:0] gp_out,
  output logic      [15:0] gp_oe_n
);
  // ==========================================================================
  // Configuration registers
  logic                 en_q, en_d;
  logic [15:0]          rxpin_q, rxpin_d, txpin_q, txpin_d;
  logic [15:0]          dbits_q, dbits_d, depth_q, depth_d;
  logic [15:0]          txcnt_q, txcnt_d, stop_q, stop_d;
  logic [15:0]          par_q, par_d, perr_q, perr_d;
  logic [31:0]          rate_q, rate_d;
  logic [3:0]           nbits;
  logic [11:0]          depth_eff;
  logic [15:0]          rate_eff;
  logic [8:0]           txcnt_eff;
  logic                 en_restart, perr_clr, perr_evt, par_on, par_odd;

  assign en_restart = reg_we && reg_addr == asp_pkg::ADDR_PORT_ENABLE &&
                      reg_wdata[15:0] != 16'h0000;
  assign perr_clr   = en_restart || (reg_we && reg_wdata[15:0] == 16'h0000 &&
                      reg_addr == asp_pkg::ADDR_PARITY_ERRS);
  assign par_on     = par_q == asp_pkg::PAR_ODD || par_q == asp_pkg::PAR_EVEN;
  assign par_odd    = par_q == asp_pkg::PAR_ODD;

  always_comb begin
    nbits = (dbits_q == 16'h0 || dbits_q > 16'h8) ? asp_pkg::DATA_BITS_MAX
            : dbits_q[3:0];
    if (depth_q == 16'h0) begin
      depth_eff = asp_pkg::RX_DEPTH_DEFAULT;
    end else if (depth_q > {4'h0, asp_pkg::RX_DEPTH_MAX}) begin
      depth_eff = asp_pkg::RX_DEPTH_MAX;
    end else begin
      depth_eff = depth_q[11:0];
    end
    rate_eff  = (rate_q > asp_pkg::RATE_MAX) ? asp_pkg::RATE_MAX[15:0]
                : rate_q[15:0];
    txcnt_eff = (txcnt_q > {7'h0, asp_pkg::TX_DEPTH}) ? asp_pkg::TX_DEPTH
                : txcnt_q[8:0];
  end

  always_comb begin
    en_d = en_q;  rxpin_d = rxpin_q;  txpin_d = txpin_q;  dbits_d = dbits_q;
    depth_d = depth_q;  txcnt_d = txcnt_q;  stop_d = stop_q;  par_d = par_q;
    rate_d = rate_q;
    if (reg_we) begin
      unique case (reg_addr)
        asp_pkg::ADDR_PORT_ENABLE: en_d    = reg_wdata[15:0] != 16'h0;
        asp_pkg::ADDR_RX_PIN:      rxpin_d = reg_wdata[15:0];
        asp_pkg::ADDR_TX_PIN:      txpin_d = reg_wdata[15:0];
        asp_pkg::ADDR_DATA_BITS:   dbits_d = reg_wdata[15:0];
        asp_pkg::ADDR_SYMBOL_RATE: rate_d  = reg_wdata;
        asp_pkg::ADDR_RX_DEPTH:    depth_d = reg_wdata[15:0];
        asp_pkg::ADDR_TX_COUNT:    txcnt_d = reg_wdata[15:0];
        asp_pkg::ADDR_STOP_BITS:   stop_d  = reg_wdata[15:0];
        asp_pkg::ADDR_PARITY:      par_d   = reg_wdata[15:0];
        default: ;
      endcase
    end
    // A new error in the clearing cycle still counts.
    perr_d = perr_clr ? 16'h0 : perr_q;
    if (perr_evt) begin
      perr_d = perr_d + 16'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      en_q <= 1'b0;  rxpin_q <= asp_pkg::CFG_RESET;
      txpin_q <= asp_pkg::CFG_RESET;  dbits_q <= asp_pkg::CFG_RESET;
      depth_q <= asp_pkg::CFG_RESET;  txcnt_q <= asp_pkg::CFG_RESET;
      stop_q <= asp_pkg::CFG_RESET;  par_q <= asp_pkg::CFG_RESET;
      perr_q <= asp_pkg::CFG_RESET;  rate_q <= asp_pkg::RATE_RESET;
    end else begin
      en_q <= en_d;  rxpin_q <= rxpin_d;  txpin_q <= txpin_d;
      dbits_q <= dbits_d;  depth_q <= depth_d;  txcnt_q <= txcnt_d;
      stop_q <= stop_d;  par_q <= par_d;  perr_q <= perr_d;  rate_q <= rate_d;
    end
  end

  // ==========================================================================
  // Symbol tick and pin routing
  asp_tick_if tick_if ();
  assign tick_if.rate = rate_eff;
  assign tick_if.run  = en_q;
  asp_rate_tick u_tick (.mclk(mclk), .srst(srst), .tk(tick_if.gen));

  logic [15:0] gp_s1_q, gp_s2_q, gp_out_d, gp_oe_n_d;
  logic        rx_line, tx_line;

  // Out-of-range pin numbers leave the port unrouted and RX reads idle.
  assign rx_line = (en_q && rxpin_q < asp_pkg::PIN_COUNT) ?
                   gp_s2_q[rxpin_q[3:0]] : 1'b1;

  always_comb begin
    gp_out_d  = 16'hffff;
    gp_oe_n_d = 16'hffff;
    if (en_q && txpin_q < asp_pkg::PIN_COUNT) begin
      gp_out_d[txpin_q[3:0]]  = tx_line;
      gp_oe_n_d[txpin_q[3:0]] = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      gp_s1_q <= 16'hffff;  gp_s2_q <= 16'hffff;
      gp_out  <= 16'hffff;  gp_oe_n <= 16'hffff;
    end else begin
      gp_s1_q <= gp_in;  gp_s2_q <= gp_s1_q;
      gp_out  <= gp_out_d;  gp_oe_n <= gp_oe_n_d;
    end
  end

  // ==========================================================================
  // Receiver and receive buffer
  asp_pkg::asp_rx_state_t rx_st_q, rx_st_d;
  logic [3:0]  rx_tc_q, rx_tc_d, rx_bit_q, rx_bit_d;
  logic [7:0]  rx_sh_q, rx_sh_d, rx_byte;
  logic        rx_par_q, rx_par_d, rx_done, rx_push, rx_pop, rx_stop_ph_q;
  logic        rx_stop_ph_d;
  logic [10:0] rxb_wp_q, rxb_wp_d, rxb_rp_q, rxb_rp_d;
  logic [11:0] rxb_cnt_q, rxb_cnt_d;
  logic [7:0]  rx_mem [0:2047];

  assign rx_byte = rx_sh_q >> (asp_pkg::DATA_BITS_MAX - nbits);
  assign rx_push = rx_done && rxb_cnt_q < depth_eff;
  assign rx_pop  = reg_re && reg_addr == asp_pkg::ADDR_RX_DATA &&
                   rxb_cnt_q != 12'h0;

  always_comb begin
    rx_st_d = rx_st_q;  rx_tc_d = rx_tc_q;  rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;  rx_par_d = rx_par_q;  rx_stop_ph_d = rx_stop_ph_q;
    rx_done = 1'b0;  perr_evt = 1'b0;
    if (tick_if.tick) begin
      rx_tc_d = rx_tc_q + 4'h1;
    end
    unique case (rx_st_q)
      asp_pkg::ASP_RX_IDLE: begin
        rx_tc_d = 4'h0;
        if (!rx_line) begin
          rx_st_d = asp_pkg::ASP_RX_START;
        end
      end
      asp_pkg::ASP_RX_START: begin
        if (tick_if.tick && rx_tc_q == asp_pkg::TICK_MID) begin
          rx_tc_d  = 4'h0;  rx_bit_d = 4'h0;  rx_par_d = 1'b0;
          // A start bit that is high again at mid bit was a glitch.
          rx_st_d  = rx_line ? asp_pkg::ASP_RX_IDLE
                     : asp_pkg::ASP_RX_DATA;
        end
      end
      asp_pkg::ASP_RX_DATA: begin
        if (tick_if.tick && rx_tc_q == asp_pkg::TICK_LAST) begin
          rx_sh_d  = {rx_line, rx_sh_q[7:1]};
          rx_par_d = rx_par_q ^ rx_line;
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q == nbits - 4'h1) begin
            rx_st_d      = asp_pkg::ASP_RX_PARITY_STOP;
            rx_stop_ph_d = !par_on;
          end
        end
      end
      asp_pkg::ASP_RX_PARITY_STOP: begin
        if (tick_if.tick && rx_tc_q == asp_pkg::TICK_LAST) begin
          if (!rx_stop_ph_q) begin
            perr_evt     = (rx_par_q ^ rx_line) != par_odd;
            rx_stop_ph_d = 1'b1;
          end else begin
            // The first stop bit is waited out but its level is not checked; a second one is idle.
            rx_done = 1'b1;
            rx_st_d = asp_pkg::ASP_RX_IDLE;
          end
        end
      end
    endcase
    if (!en_q || en_restart) begin
      rx_st_d = asp_pkg::ASP_RX_IDLE;
    end
  end

  always_comb begin
    rxb_wp_d  = rxb_wp_q + {10'h0, rx_push};
    rxb_rp_d  = rxb_rp_q + {10'h0, rx_pop};
    rxb_cnt_d = rxb_cnt_q + {11'h0, rx_push} - {11'h0, rx_pop};
    if (en_restart) begin
      rxb_wp_d = 11'h0;  rxb_rp_d = 11'h0;  rxb_cnt_d = 12'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_st_q <= asp_pkg::ASP_RX_IDLE;
      rx_tc_q <= 4'h0;  rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;  rx_par_q <= 1'b0;  rx_stop_ph_q <= 1'b0;
      rxb_wp_q <= 11'h0;  rxb_rp_q <= 11'h0;  rxb_cnt_q <= 12'h0;
    end else begin
      rx_st_q <= rx_st_d;  rx_tc_q <= rx_tc_d;  rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;  rx_par_q <= rx_par_d;  rx_stop_ph_q <= rx_stop_ph_d;
      rxb_wp_q <= rxb_wp_d;  rxb_rp_q <= rxb_rp_d;  rxb_cnt_q <= rxb_cnt_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rx_push) begin
      rx_mem[rxb_wp_q] <= rx_byte;
    end
  end

  // ==========================================================================
  // Transmitter and transmit buffer
  asp_pkg::asp_tx_state_t tx_st_q, tx_st_d;
  logic [3:0] tx_tc_q, tx_tc_d, tx_bit_q, tx_bit_d;
  logic [7:0] tx_sh_q, tx_sh_d;
  logic [8:0] tx_idx_q, tx_idx_d, tx_left_q, tx_left_d, txb_wp_q, txb_wp_d;
  logic       tx_par_q, tx_par_d, tx_go, tx_wr, tx_fin, bit_end;
  logic [7:0] tx_mem [0:255];

  assign bit_end = tick_if.tick && tx_tc_q == asp_pkg::TICK_LAST;
  assign tx_go   = reg_we && reg_addr == asp_pkg::ADDR_TX_TRIGGER &&
                   reg_wdata[15:0] == asp_pkg::TRIGGER_GO && en_q &&
                   tx_st_q == asp_pkg::ASP_TX_IDLE &&
                   txcnt_eff != 9'h0;
  // The buffer is frozen while a burst is going out.
  assign tx_wr   = reg_we && reg_addr == asp_pkg::ADDR_TX_DATA &&
                   tx_st_q == asp_pkg::ASP_TX_IDLE &&
                   txb_wp_q < asp_pkg::TX_DEPTH;

  always_comb begin
    unique case (tx_st_q)
      asp_pkg::ASP_TX_START:  tx_line = 1'b0;
      asp_pkg::ASP_TX_DATA:   tx_line = tx_sh_q[0];
      asp_pkg::ASP_TX_PARITY: tx_line = tx_par_q ^ par_odd;
      default:       tx_line = 1'b1;
    endcase
  end

  always_comb begin
    tx_st_d = tx_st_q;  tx_tc_d = tx_tc_q;  tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;  tx_par_d = tx_par_q;  tx_idx_d = tx_idx_q;
    tx_left_d = tx_left_q;  tx_fin = 1'b0;
    if (tick_if.tick) begin
      tx_tc_d = tx_tc_q + 4'h1;
    end
    unique case (tx_st_q)
      asp_pkg::ASP_TX_IDLE: begin
        if (tx_go) begin
          tx_left_d = txcnt_eff;
          tx_idx_d  = 9'h0;
          tx_st_d   = asp_pkg::ASP_TX_LOAD;
        end
      end
      asp_pkg::ASP_TX_LOAD: begin
        tx_sh_d  = tx_mem[tx_idx_q[7:0]];
        tx_par_d = 1'b0;  tx_tc_d = 4'h0;  tx_bit_d = 4'h0;
        tx_st_d  = asp_pkg::ASP_TX_START;
      end
      asp_pkg::ASP_TX_START: begin
        if (bit_end) begin
          tx_st_d = asp_pkg::ASP_TX_DATA;
        end
      end
      asp_pkg::ASP_TX_DATA: begin
        if (bit_end) begin
          tx_par_d = tx_par_q ^ tx_sh_q[0];
          tx_sh_d  = {1'b0, tx_sh_q[7:1]};
          tx_bit_d = tx_bit_q + 4'h1;
          if (tx_bit_q == nbits - 4'h1) begin
            tx_bit_d = 4'h0;
            tx_st_d  = par_on ? asp_pkg::ASP_TX_PARITY
                       : asp_pkg::ASP_TX_STOP;
          end
        end
      end
      asp_pkg::ASP_TX_PARITY: begin
        if (bit_end) begin
          tx_st_d = asp_pkg::ASP_TX_STOP;
        end
      end
      asp_pkg::ASP_TX_STOP: begin
        if (bit_end) begin
          if (tx_bit_q == 4'h0 && stop_q == asp_pkg::STOP_TWO) begin
            tx_bit_d = 4'h1;
          end else begin
            tx_left_d = tx_left_q - 9'h1;
            tx_idx_d  = tx_idx_q + 9'h1;
            tx_fin    = tx_left_q == 9'h1;
            tx_st_d   = tx_fin ? asp_pkg::ASP_TX_IDLE
                        : asp_pkg::ASP_TX_LOAD;
          end
        end
      end
    endcase
    if (!en_q || en_restart) begin
      tx_st_d = asp_pkg::ASP_TX_IDLE;
    end
    txb_wp_d = txb_wp_q + {8'h00, tx_wr};
    if (tx_fin || en_restart) begin
      txb_wp_d = 9'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_st_q <= asp_pkg::ASP_TX_IDLE;
      tx_tc_q <= 4'h0;  tx_bit_q <= 4'h0;
      tx_sh_q <= 8'h00;  tx_par_q <= 1'b0;  tx_idx_q <= 9'h0;
      tx_left_q <= 9'h0;  txb_wp_q <= 9'h0;
    end else begin
      tx_st_q <= tx_st_d;  tx_tc_q <= tx_tc_d;  tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;  tx_par_q <= tx_par_d;  tx_idx_q <= tx_idx_d;
      tx_left_q <= tx_left_d;  txb_wp_q <= txb_wp_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (tx_wr) begin
      tx_mem[txb_wp_q[7:0]] <= reg_wdata[7:0];
    end
  end

  // ==========================================================================
  // Register read port
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = reg_rdata;
    if (reg_re) begin
      unique case (reg_addr)
        asp_pkg::ADDR_PORT_ENABLE: rdata_d = {31'h0, en_q};
        asp_pkg::ADDR_RX_PIN:      rdata_d = {16'h0, rxpin_q};
        asp_pkg::ADDR_TX_PIN:      rdata_d = {16'h0, txpin_q};
        asp_pkg::ADDR_DATA_BITS:   rdata_d = {16'h0, dbits_q};
        asp_pkg::ADDR_SYMBOL_RATE: rdata_d = rate_q;
        asp_pkg::ADDR_RX_DEPTH:    rdata_d = {16'h0, depth_q};
        asp_pkg::ADDR_RX_COUNT:    rdata_d = {20'h0, rxb_cnt_q};
        asp_pkg::ADDR_TX_COUNT:    rdata_d = {16'h0, txcnt_q};
        asp_pkg::ADDR_STOP_BITS:   rdata_d = {16'h0, stop_q};
        asp_pkg::ADDR_PARITY:      rdata_d = {16'h0, par_q};
        asp_pkg::ADDR_PARITY_ERRS: rdata_d = {16'h0, perr_q};
        asp_pkg::ADDR_RX_DATA:     rdata_d = rx_pop ?
                                   {24'h0, rx_mem[rxb_rp_q]} : 32'h0;
        default:                   rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_go;
    tx_go;
  endsequence
  sequence s_frame_start;
    ##[1:2] (tx_st_q == asp_pkg::ASP_TX_START)
    ##1 (gp_out[txpin_q[3:0]] == 1'b0);
  endsequence

  AST_RATE_CAP: assert property (
    {16'h0, rate_eff} <= asp_pkg::RATE_MAX)
    else $error("rate above cap");
  AST_BITS_ZERO: assert property (dbits_q == 16'h0 |-> nbits == 4'h8)
    else $error("zero data bits not eight");
  AST_DEPTH_DEF: assert property (
    depth_q == 16'h0 |-> depth_eff == 12'h0c8)
    else $error("default depth wrong");
  // An enable write empties the buffer, so it is left out here.
  AST_RX_CAP: assert property ((rx_done && !rx_pop && !en_restart &&
    rxb_cnt_q >= depth_eff) |=> $stable(rxb_cnt_q))
    else $error("buffer grew beyond depth");
  AST_UNDERRUN: assert property ((reg_re && rxb_cnt_q == 12'h0 &&
    reg_addr == asp_pkg::ADDR_RX_DATA) |=> reg_rdata == 32'h0)
    else $error("empty read not zero");
  AST_COUNT_READ: assert property ((reg_re &&
    reg_addr == asp_pkg::ADDR_RX_COUNT) |=> reg_rdata[11:0] == $past(rxb_cnt_q))
    else $error("count readback wrong");
  AST_PERR_CLEAR: assert property ((perr_clr && !perr_evt)
    |=> perr_q == 16'h0)
    else $error("parity counter not cleared");
  AST_PERR_INC: assert property ((perr_evt && !perr_clr)
    |=> perr_q == $past(perr_q) + 16'h1)
    else $error("parity counter not counted");
  AST_TX_APPEND: assert property (
    tx_wr |=> txb_wp_q == $past(txb_wp_q) + 9'h1)
    else $error("tx write did not append");
  AST_ONE_PIN: assert property ($countones(~gp_oe_n) <= 1)
    else $error("more than one pin driven");
  AST_START_BIT: assert property ((s_go and (txpin_q <
    asp_pkg::PIN_COUNT)) |-> s_frame_start)
    else $error("frame did not start low");
  // Watches the pin itself, so a fault in the output register shows too.
  AST_STOP_HIGH: assert property ((tx_st_q == asp_pkg::ASP_TX_STOP &&
    en_q && txpin_q < asp_pkg::PIN_COUNT) |=> gp_out[$past(txpin_q[3:0])])
    else $error("stop bit not high");

endmodule // asp_async_serial_port

//--- dv/asp_serial_peer.sv
`timescale 1ns/10ps
// ============================================================================
// Far-side device: 8 data bits, even parity, line idles high.
module asp_serial_peer #(
  parameter real BIT_NS = 26041.67
) (
  input  wire logic tx_line,
  output logic      rx_line
);
  logic [7:0] got_q[$];
  int         bad_frames;
  logic [7:0] sh;
  logic       par;

  initial begin
    rx_line = 1'b1;
    bad_frames = 0;
  end

  // A flip of the parity bit lets the bench provoke a parity fault.
  task automatic send(input logic [7:0] b, input logic flip);
    rx_line = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rx_line = b[i];
      #(BIT_NS);
    end
    rx_line = ^b ^ flip;
    #(BIT_NS);
    rx_line = 1'b1;
    #(BIT_NS);
  endtask

  // Samples mid-bit, so rate jitter of a few clocks does no harm.
  always begin
    @(negedge tx_line);
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS);
      sh[i] = tx_line;
    end
    #(BIT_NS);
    par = tx_line;
    #(BIT_NS);
    if (par !== ^sh || tx_line !== 1'b1) bad_frames++;
    #(BIT_NS);
    if (tx_line !== 1'b1) bad_frames++;
    got_q.push_back(sh);
  end
endmodule // asp_serial_peer

//--- dv/asp_async_serial_port_tb.sv
`timescale 1ns/10ps
module asp_async_serial_port_tb;
  localparam int  TXP    = 3;
  localparam int  RXP    = 5;
  localparam real BIT_NS = 1.0e9 / 38400.0;

  logic        mclk;
  logic        srst;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic [31:0] reg_rdata;
  logic [15:0] gp_in;
  logic [15:0] gp_out;
  logic [15:0] gp_oe_n;
  logic        tx_line;
  logic        rx_line;
  logic [31:0] rv;
  int          errors;
  int          total_checks;

  asp_async_serial_port u_dut (
    .mclk      (mclk),
    .srst      (srst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_we    (reg_we),
    .reg_re    (reg_re),
    .reg_rdata (reg_rdata),
    .gp_in     (gp_in),
    .gp_out    (gp_out),
    .gp_oe_n   (gp_oe_n)
  );

  asp_serial_peer #(.BIT_NS(BIT_NS)) u_peer (
    .tx_line (tx_line),
    .rx_line (rx_line)
  );

  // Undriven pins are pulled high on the board.
  assign tx_line = gp_oe_n[TXP] ? 1'b1 : gp_out[TXP];
  always_comb begin
    gp_in = 16'hffff;
    gp_in[RXP] = rx_line;
  end

  // ==========================================================================
  // Access tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge mclk);
    reg_we = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge mclk);
    reg_re = 1'b0;
    d = reg_rdata;
  endtask

  task automatic cfg(input logic [15:0] a, input logic [31:0] d);
    wr(a, d);
    rd(a, rv);
    chk(rv, d);
  endtask

  task automatic finish_test();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and tests
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #1_000_000;
    errors++;
    finish_test();
  end

  initial begin
    srst = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 32'h0000_0000;
    reg_we = 1'b0;
    reg_re = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    rd(asp_pkg::ADDR_PORT_ENABLE, rv);
    chk(rv, 32'h0000_0000);
    rd(asp_pkg::ADDR_SYMBOL_RATE, rv);
    chk(rv, asp_pkg::RATE_RESET);
    rd(16'h1500, rv);
    chk(rv, 32'h0000_0000);
    rd(asp_pkg::ADDR_TX_DATA, rv);
    chk(rv, 32'h0000_0000);
    chk({16'h0000, gp_oe_n}, 32'h0000_ffff);
    cfg(asp_pkg::ADDR_TX_PIN, TXP);
    cfg(asp_pkg::ADDR_RX_PIN, RXP);
    cfg(asp_pkg::ADDR_SYMBOL_RATE, 32'h0000_9600);
    cfg(asp_pkg::ADDR_DATA_BITS, 32'h0000_0000);
    cfg(asp_pkg::ADDR_STOP_BITS, 32'h0000_0002);
    cfg(asp_pkg::ADDR_PARITY, 32'h0000_0002);
    cfg(asp_pkg::ADDR_RX_DEPTH, 32'h0000_0000);
    wr(asp_pkg::ADDR_PORT_ENABLE, 32'h0000_0001);
    repeat (3) @(negedge mclk);
    chk({16'h0000, gp_oe_n}, 32'h0000_fff7);
    // A third byte is loaded but the count of two must hold it back.
    wr(asp_pkg::ADDR_TX_COUNT, 32'h0000_0002);
    wr(asp_pkg::ADDR_TX_DATA, 32'h0000_0096);
    wr(asp_pkg::ADDR_TX_DATA, 32'h0000_000f);
    wr(asp_pkg::ADDR_TX_DATA, 32'h0000_0055);
    fork
      wr(asp_pkg::ADDR_TX_TRIGGER, 32'h0000_0001);
      begin
        u_peer.send(8'ha5, 1'b0);
        u_peer.send(8'h3c, 1'b1);
      end
    join
    for (int i = 0; i < 80000 && u_peer.got_q.size() < 2; i++) begin
      @(negedge mclk);
    end
    #(2.0 * BIT_NS);
    chk(u_peer.got_q.size(), 2);
    chk(u_peer.got_q[0], 8'h96);
    chk(u_peer.got_q[1], 8'h0f);
    chk(u_peer.bad_frames, 0);
    rd(asp_pkg::ADDR_RX_COUNT, rv);
    chk(rv, 32'h0000_0002);
    rd(asp_pkg::ADDR_RX_DATA, rv);
    chk(rv[7:0], 8'ha5);
    rd(asp_pkg::ADDR_RX_DATA, rv);
    chk(rv[7:0], 8'h3c);
    rd(asp_pkg::ADDR_RX_DATA, rv);
    chk(rv, 32'h0000_0000);
    // A second read of the empty data port also returns zero.
    rd(asp_pkg::ADDR_RX_DATA, rv);
    chk(rv, 32'h0000_0000);
    rd(asp_pkg::ADDR_RX_COUNT, rv);
    chk(rv, 32'h0000_0000);
    rd(asp_pkg::ADDR_PARITY_ERRS, rv);
    chk(rv, 32'h0000_0001);
    wr(asp_pkg::ADDR_PARITY_ERRS, 32'h0000_0000);
    rd(asp_pkg::ADDR_PARITY_ERRS, rv);
    chk(rv, 32'h0000_0000);
    finish_test();
  end
endmodule // asp_async_serial_port_tb
